// >>> rtl/rtcal_alarm_cmp.sv
`timescale 1ns/1ps
// Function
// RULE1 - Hour target bit 7 enables, bit 6 unused.
// RULE2 - Hour value 24h BCD or 12h PM.
// RULE3 - Day target 1-31 BCD, bit 7 enable.
// RULE4 - Weekday target 1-7, bit 7 enable.
// RULE5 - Month target 1-12 BCD, bit 7 enable.
// RULE6 - Year target 0-79 BCD, bit 7 enable.
// RULE7 - Bit 7 clear disables field comparison.
// RULE8 - Alarm on first full AND match only.
// RULE9 - Match with irq enable sets flag, interrupt.
// RULE10 - Disabled targets ignored in match evaluation.
// RULE11 - Seconds target 0-59 BCD joins comparison.
// RULE12 - Unused bits read zero, writes ignored.
module rtcal_alarm_cmp (
   // Clock, reset and enable.
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_NRST,
   input  wire logic        I_CE,
   // Register port.
   input  wire logic [7:0]  I_REG_ADDR,
   input  wire logic        I_REG_WR,
   input  wire logic        I_REG_RD,
   input  wire logic [7:0]  I_REG_WDATA,
   output logic      [7:0]  O_REG_RDATA,
   // Running time and date counters.
   input  wire logic [6:0]  I_CUR_SEC,
   input  wire logic [6:0]  I_CUR_MIN,
   input  wire logic [5:0]  I_CUR_HOUR,
   input  wire logic [5:0]  I_CUR_DAY,
   input  wire logic [2:0]  I_CUR_WDAY,
   input  wire logic [4:0]  I_CUR_MONTH,
   input  wire logic [6:0]  I_CUR_YEAR,
   // Alarm control and status.
   input  wire logic        I_MATCH_IRQ_ENABLE,
   input  wire logic        I_MATCH_FLAG_CLR,
   output logic             O_MATCH_FLAG,
   output logic             O_IRQ
);

   logic [7:0] sec_target_r;
   logic [7:0] min_target_r;
   logic [7:0] hour_target_r;
   logic [7:0] day_target_r;
   logic [7:0] wday_target_r;
   logic [7:0] month_target_r;
   logic [7:0] year_target_r;
   logic       all_match_r;

   // Only the enable bit and the value field are stored. [RULE12]
   localparam logic [7:0] EN_MASK    = 8'h80;
   localparam logic [7:0] SEC_MASK   = EN_MASK | 8'((1 << rtcal_pkg::SEC_W) - 1);   // [RULE11]
   localparam logic [7:0] MIN_MASK   = EN_MASK | 8'((1 << rtcal_pkg::MIN_W) - 1);
   localparam logic [7:0] HOUR_MASK  = EN_MASK | 8'((1 << rtcal_pkg::HOUR_W) - 1);  // [RULE1]
   localparam logic [7:0] DAY_MASK   = EN_MASK | 8'((1 << rtcal_pkg::DAY_W) - 1);   // [RULE3]
   localparam logic [7:0] WDAY_MASK  = EN_MASK | 8'((1 << rtcal_pkg::WDAY_W) - 1);  // [RULE4]
   localparam logic [7:0] MONTH_MASK = EN_MASK | 8'((1 << rtcal_pkg::MONTH_W) - 1); // [RULE5]
   localparam logic [7:0] YEAR_MASK  = EN_MASK | 8'((1 << rtcal_pkg::YEAR_W) - 1);  // [RULE6]

   // Address decode, shared by writes and reads.
   wire sel_sec_w   = (I_REG_ADDR == rtcal_pkg::SEC_TARGET_OFS);
   wire sel_min_w   = (I_REG_ADDR == rtcal_pkg::MIN_TARGET_OFS);
   wire sel_hour_w  = (I_REG_ADDR == rtcal_pkg::HOUR_TARGET_OFS);
   wire sel_day_w   = (I_REG_ADDR == rtcal_pkg::DAY_TARGET_OFS);
   wire sel_wday_w  = (I_REG_ADDR == rtcal_pkg::WDAY_TARGET_OFS);
   wire sel_month_w = (I_REG_ADDR == rtcal_pkg::MONTH_TARGET_OFS);
   wire sel_year_w  = (I_REG_ADDR == rtcal_pkg::YEAR_TARGET_OFS);

   // Write strobes.
   wire wr_sec_w   = I_REG_WR & sel_sec_w;
   wire wr_min_w   = I_REG_WR & sel_min_w;
   wire wr_hour_w  = I_REG_WR & sel_hour_w;
   wire wr_day_w   = I_REG_WR & sel_day_w;
   wire wr_wday_w  = I_REG_WR & sel_wday_w;
   wire wr_month_w = I_REG_WR & sel_month_w;
   wire wr_year_w  = I_REG_WR & sel_year_w;

   // Next target values keep only the enable bit and the value field. [RULE12]
   wire [7:0] sec_target_nxt   = I_REG_WDATA & SEC_MASK;   // [RULE11]
   wire [7:0] min_target_nxt   = I_REG_WDATA & MIN_MASK;
   wire [7:0] hour_target_nxt  = I_REG_WDATA & HOUR_MASK;  // [RULE1]
   wire [7:0] day_target_nxt   = I_REG_WDATA & DAY_MASK;   // [RULE3]
   wire [7:0] wday_target_nxt  = I_REG_WDATA & WDAY_MASK;  // [RULE4]
   wire [7:0] month_target_nxt = I_REG_WDATA & MONTH_MASK; // [RULE5]
   wire [7:0] year_target_nxt  = I_REG_WDATA & YEAR_MASK;  // [RULE6]

   // Read selection; unmapped addresses read zero. [RULE12]
   wire [7:0] rd_sel_w = ({8{sel_sec_w}}   & sec_target_r)   |
                         ({8{sel_min_w}}   & min_target_r)   |
                         ({8{sel_hour_w}}  & hour_target_r)  |
                         ({8{sel_day_w}}   & day_target_r)   |
                         ({8{sel_wday_w}}  & wday_target_r)  |
                         ({8{sel_month_w}} & month_target_r) |
                         ({8{sel_year_w}}  & year_target_r);

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         sec_target_r <= rtcal_pkg::TARGET_RST;
      end else if (I_CE && wr_sec_w) begin
         sec_target_r <= sec_target_nxt;     // [RULE11]
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         min_target_r <= rtcal_pkg::TARGET_RST;
      end else if (I_CE && wr_min_w) begin
         min_target_r <= min_target_nxt;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         hour_target_r <= rtcal_pkg::TARGET_RST;
      end else if (I_CE && wr_hour_w) begin
         hour_target_r <= hour_target_nxt;   // [RULE1] [RULE2]
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         day_target_r <= rtcal_pkg::TARGET_RST;
      end else if (I_CE && wr_day_w) begin
         day_target_r <= day_target_nxt;     // [RULE3]
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         wday_target_r <= rtcal_pkg::TARGET_RST;
      end else if (I_CE && wr_wday_w) begin
         wday_target_r <= wday_target_nxt;   // [RULE4]
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         month_target_r <= rtcal_pkg::TARGET_RST;
      end else if (I_CE && wr_month_w) begin
         month_target_r <= month_target_nxt; // [RULE5]
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         year_target_r <= rtcal_pkg::TARGET_RST;
      end else if (I_CE && wr_year_w) begin
         year_target_r <= year_target_nxt;   // [RULE6]
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_REG_RDATA <= rtcal_pkg::RDATA_RST;
      end else if (I_CE && I_REG_RD) begin
         O_REG_RDATA <= rd_sel_w;
      end
   end

   // Field comparators.
   rtcal_fld_if #(.W(rtcal_pkg::SEC_W))   f_sec ();
   rtcal_fld_if #(.W(rtcal_pkg::MIN_W))   f_min ();
   rtcal_fld_if #(.W(rtcal_pkg::HOUR_W))  f_hour ();
   rtcal_fld_if #(.W(rtcal_pkg::DAY_W))   f_day ();
   rtcal_fld_if #(.W(rtcal_pkg::WDAY_W))  f_wday ();
   rtcal_fld_if #(.W(rtcal_pkg::MONTH_W)) f_month ();
   rtcal_fld_if #(.W(rtcal_pkg::YEAR_W))  f_year ();

   assign f_sec.en        = sec_target_r[rtcal_pkg::MATCH_EN_BIT];   // [RULE11]
   assign f_sec.target    = sec_target_r[rtcal_pkg::SEC_W-1:0];
   assign f_sec.current   = I_CUR_SEC;
   assign f_min.en        = min_target_r[rtcal_pkg::MATCH_EN_BIT];
   assign f_min.target    = min_target_r[rtcal_pkg::MIN_W-1:0];
   assign f_min.current   = I_CUR_MIN;
   assign f_hour.en       = hour_target_r[rtcal_pkg::MATCH_EN_BIT];  // [RULE1]
   // The afternoon flag sits inside the compared field, so 12h and 24h
   // coding both compare bits 5 to 0 directly. [RULE2]
   assign f_hour.target   = hour_target_r[rtcal_pkg::HOUR_W-1:0];
   assign f_hour.current  = I_CUR_HOUR;
   assign f_day.en        = day_target_r[rtcal_pkg::MATCH_EN_BIT];   // [RULE3] [RULE7]
   assign f_day.target    = day_target_r[rtcal_pkg::DAY_W-1:0];
   assign f_day.current   = I_CUR_DAY;
   assign f_wday.en       = wday_target_r[rtcal_pkg::MATCH_EN_BIT];  // [RULE4] [RULE7]
   assign f_wday.target   = wday_target_r[rtcal_pkg::WDAY_W-1:0];
   assign f_wday.current  = I_CUR_WDAY;
   assign f_month.en      = month_target_r[rtcal_pkg::MATCH_EN_BIT]; // [RULE5] [RULE7]
   assign f_month.target  = month_target_r[rtcal_pkg::MONTH_W-1:0];
   assign f_month.current = I_CUR_MONTH;
   assign f_year.en       = year_target_r[rtcal_pkg::MATCH_EN_BIT];  // [RULE6] [RULE7]
   assign f_year.target   = year_target_r[rtcal_pkg::YEAR_W-1:0];
   assign f_year.current  = I_CUR_YEAR;

   rtcal_field_cmp #(.W(rtcal_pkg::SEC_W))   u_sec   (.f(f_sec));
   rtcal_field_cmp #(.W(rtcal_pkg::MIN_W))   u_min   (.f(f_min));
   rtcal_field_cmp #(.W(rtcal_pkg::HOUR_W))  u_hour  (.f(f_hour));
   rtcal_field_cmp #(.W(rtcal_pkg::DAY_W))   u_day   (.f(f_day));
   rtcal_field_cmp #(.W(rtcal_pkg::WDAY_W))  u_wday  (.f(f_wday));
   rtcal_field_cmp #(.W(rtcal_pkg::MONTH_W)) u_month (.f(f_month));
   rtcal_field_cmp #(.W(rtcal_pkg::YEAR_W))  u_year  (.f(f_year));

   // At least one field must be enabled for a match to count.
   wire any_en_w    = f_sec.en | f_min.en | f_hour.en | f_day.en |
                      f_wday.en | f_month.en | f_year.en;
   // Wired AND of all enabled comparisons. [RULE8] [RULE10]
   wire all_match_w = any_en_w & f_sec.hit & f_min.hit & f_hour.hit & f_day.hit &
                      f_wday.hit & f_month.hit & f_year.hit;
   // Only the first cycle of a match raises the alarm. [RULE8]
   wire first_w     = all_match_w & ~all_match_r;
   wire set_flag_w  = first_w & I_MATCH_IRQ_ENABLE;                      // [RULE9]
   // A fresh match wins over a clear in the same cycle.
   wire flag_nxt    = set_flag_w | (O_MATCH_FLAG & ~I_MATCH_FLAG_CLR);
   wire irq_nxt     = flag_nxt & I_MATCH_IRQ_ENABLE;                      // [RULE9]

   // Match history for the first-occasion test.
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         all_match_r <= 1'b0;
      end else if (I_CE) begin
         all_match_r <= all_match_w;                                      // [RULE8]
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_MATCH_FLAG <= 1'b0;
      end else if (I_CE) begin
         O_MATCH_FLAG <= flag_nxt;                                        // [RULE9]
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_IRQ <= 1'b0;
      end else if (I_CE) begin
         O_IRQ <= irq_nxt;                                                // [RULE9]
      end
   end

endmodule

// >>> rtl/rtcal_pkg.sv
package rtcal_pkg;

   // Register offsets on the byte-wide register port.
   localparam logic [7:0] SEC_TARGET_OFS   = 8'h10;
   localparam logic [7:0] MIN_TARGET_OFS   = 8'h11;
   localparam logic [7:0] HOUR_TARGET_OFS  = 8'h12;
   localparam logic [7:0] DAY_TARGET_OFS   = 8'h13;
   localparam logic [7:0] WDAY_TARGET_OFS  = 8'h14;
   localparam logic [7:0] MONTH_TARGET_OFS = 8'h15;
   localparam logic [7:0] YEAR_TARGET_OFS  = 8'h16;

   // Field layout common to all target registers.
   localparam int         MATCH_EN_BIT     = 7;

   // Value field widths, starting at bit 0.
   localparam int         SEC_W            = 7;
   localparam int         MIN_W            = 7;
   localparam int         HOUR_W           = 6;
   localparam int         DAY_W            = 6;
   localparam int         WDAY_W           = 3;
   localparam int         MONTH_W          = 5;
   localparam int         YEAR_W           = 7;

   // Position of the afternoon flag within the hour target.
   localparam int         AFTERNOON_BIT    = 5;

   // Reset values.
   localparam logic [7:0] TARGET_RST       = 8'h00;
   localparam logic [7:0] RDATA_RST        = 8'h00;

   // Number of compared fields.
   localparam int         NUM_FIELDS       = 7;

endpackage

// >>> rtl/rtcal_fld_if.sv
`timescale 1ns/1ps
interface rtcal_fld_if #(
   parameter int W = 7
);
   logic         en;
   logic [W-1:0] target;
   logic [W-1:0] current;
   logic         hit;

   modport owner (output en, output target, output current, input hit);
   modport cmp   (input en, input target, input current, output hit);
endinterface

// >>> rtl/rtcal_field_cmp.sv
`timescale 1ns/1ps
module rtcal_field_cmp #(
   parameter int W = 7
) (
   rtcal_fld_if.cmp f
);

   wire equal_w;

   assign equal_w = (f.target == f.current);
   // A disabled field never blocks the match. [RULE7] [RULE10]
   assign f.hit   = ~f.en | equal_w;

endmodule

// >>> dv/rtcal_alarm_monitor.sv
`timescale 1ns/1ps
module rtcal_alarm_monitor (
   // Clock, reset and enable.
   input wire logic       I_CORE_CLK,
   input wire logic       I_NRST,
   input wire logic       I_CE,
   // Register port.
   input wire logic [7:0] I_REG_ADDR,
   input wire logic       I_REG_RD,
   input wire logic [7:0] O_REG_RDATA,
   // Alarm control and status.
   input wire logic       I_MATCH_IRQ_ENABLE,
   input wire logic       I_MATCH_FLAG_CLR,
   input wire logic       O_MATCH_FLAG,
   input wire logic       O_IRQ
);
   wire logic rd_go = I_REG_RD && I_CE;
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_NRST);
   property p_hr; rd_go && I_REG_ADDR == 8'h12 |=> !O_REG_RDATA[6]; endproperty
   a_hr: assert property (p_hr) else $error("hour spare bit read set");
   property p_dy; rd_go && I_REG_ADDR == 8'h13 |=> !O_REG_RDATA[6]; endproperty
   a_dy: assert property (p_dy) else $error("day spare bit read set");
   property p_wd; rd_go && I_REG_ADDR == 8'h14 |=> O_REG_RDATA[6:3] == 4'h0; endproperty
   a_wd: assert property (p_wd) else $error("weekday spare bits set");
   property p_mo; rd_go && I_REG_ADDR == 8'h15 |=> O_REG_RDATA[6:5] == 2'h0; endproperty
   a_mo: assert property (p_mo) else $error("month spare bits set");
   property p_un; rd_go && (I_REG_ADDR > 8'h16 || I_REG_ADDR < 8'h10) |=> O_REG_RDATA == 8'h00;
   endproperty
   a_un: assert property (p_un) else $error("unmapped read not zero");
   property p_hd; !rd_go |=> $stable(O_REG_RDATA); endproperty
   a_hd: assert property (p_hd) else $error("read data moved");
   property p_st; $rose(O_MATCH_FLAG) |-> $past(I_MATCH_IRQ_ENABLE); endproperty
   a_st: assert property (p_st) else $error("flag set without enable");
   property p_kp; O_MATCH_FLAG && I_CE && !I_MATCH_FLAG_CLR |=> O_MATCH_FLAG; endproperty
   a_kp: assert property (p_kp) else $error("flag dropped");
   property p_iq; I_CE |=> O_IRQ == (O_MATCH_FLAG && $past(I_MATCH_IRQ_ENABLE)); endproperty
   a_iq: assert property (p_iq) else $error("irq not flag and enable");
   property p_cl; O_MATCH_FLAG && I_CE && I_MATCH_FLAG_CLR && !I_MATCH_IRQ_ENABLE
      |=> !O_MATCH_FLAG; endproperty
   a_cl: assert property (p_cl) else $error("flag kept after clear");
   property p_fz; !I_CE |=> $stable(O_MATCH_FLAG) && $stable(O_IRQ); endproperty
   a_fz: assert property (p_fz) else $error("flag moved while frozen");
endmodule
bind rtcal_alarm_cmp rtcal_alarm_monitor u_mon (.I_CORE_CLK, .I_NRST, .I_CE, .I_REG_ADDR,
   .I_REG_RD, .O_REG_RDATA, .I_MATCH_IRQ_ENABLE, .I_MATCH_FLAG_CLR, .O_MATCH_FLAG, .O_IRQ);

// >>> dv/rtcal_host.sv
`timescale 1ns/1ps
module rtcal_host (
   // Clock.
   input  wire logic       i_clk,
   // Register port.
   output logic      [7:0] o_addr,
   output logic            o_wr,
   output logic            o_rd,
   output logic      [7:0] o_wdata,
   input  wire logic [7:0] i_rdata
);
   initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
   // One byte access; idle address and data show the inverse of the last value.
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge i_clk) #1 {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
      @(posedge i_clk) #1 {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
      q = i_rdata;
   endtask
endmodule

// >>> dv/calendar_alarm_compare_tb.sv
`timescale 1ns/1ps
module calendar_alarm_compare_tb;
   logic                  clk, nrst, wr, rd, en, clr, flag, irq, ce;
   logic            [7:0] addr, wdata, rdata, q;
   logic            [6:0] sec, yr, mn;
   logic            [5:0] hr, day;
   logic            [4:0] mon;
   logic            [2:0] wd;
   int                    err_total, num_checks;
   localparam logic [7:0] MASK [7] = '{8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'h9f, 8'hff};
   localparam logic [7:0] TGT [7] = '{8'hd9, 8'h00, 8'hb2, 8'h05, 8'h00, 8'h00, 8'h00};
   rtcal_alarm_cmp uut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_CE(ce), .I_REG_ADDR(addr),
      .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
      .I_CUR_SEC(sec), .I_CUR_MIN(mn), .I_CUR_HOUR(hr), .I_CUR_DAY(day), .I_CUR_WDAY(wd),
      .I_CUR_MONTH(mon), .I_CUR_YEAR(yr), .I_MATCH_IRQ_ENABLE(en), .I_MATCH_FLAG_CLR(clr),
      .O_MATCH_FLAG(flag), .O_IRQ(irq));
   rtcal_host u_host (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
      .i_rdata(rdata));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic end_of_test();
      if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Reset values, write masks and the unmapped place just above the targets.
   task automatic t_regs();
      for (int i = 0; i < 8; i++) begin
         u_host.xfer(1'b0, 8'h10 + 8'(i), 8'h00, q);
         chk(q, 8'h00);
         u_host.xfer(1'b1, 8'h10 + 8'(i), 8'hff, q);
         u_host.xfer(1'b0, 8'h10 + 8'(i), 8'h00, q);
         chk(q, (i < 7) ? MASK[i] : 8'h00);
      end
   endtask
   // Seconds and afternoon hour enabled, day disabled and different.
   task automatic t_match();
      for (int i = 0; i < 7; i++) u_host.xfer(1'b1, 8'h10 + 8'(i), TGT[i], q);
      {en, sec, hr, day} = {1'b0, 7'h59, 6'h32, 6'h09};
      tick(2);
      chk({6'h00, flag, irq}, 8'h00);
      en = 1'b1;
      tick(2);
      chk({6'h00, flag, irq}, 8'h00);
      sec = 7'h58;
      tick(1);
      sec = 7'h59;
      tick(1);
      chk({6'h00, flag, irq}, 8'h03);
      en = 1'b0;
      tick(1);
      chk({6'h00, flag, irq}, 8'h02);
      clr = 1'b1;
      tick(1);
      {clr, en, hr} = {1'b0, 1'b1, 6'h12};
      chk({6'h00, flag, irq}, 8'h00);
      tick(2);
      chk({6'h00, flag, irq}, 8'h00);
      hr = 6'h32;
      tick(1);
      chk({6'h00, flag, irq}, 8'h03);
   endtask
   // Every field enabled; one wrong field blocks, a fresh match beats a clear.
   task automatic t_date();
      u_host.xfer(1'b1, 8'h11, 8'hb0, q);
      u_host.xfer(1'b1, 8'h13, 8'hb1, q);
      u_host.xfer(1'b1, 8'h14, 8'h83, q);
      u_host.xfer(1'b1, 8'h15, 8'h92, q);
      u_host.xfer(1'b1, 8'h16, 8'hf9, q);
      {yr, clr} = {7'h79, 1'b0};
      for (int k = 0; k < 4; k++) begin
         {clr, day, wd, mon, mn} = {1'b1, 6'h31, 3'h3, 5'h12, 7'h30};
         if (k == 0) day = 6'h30;
         if (k == 1) wd = 3'h4;
         if (k == 2) mon = 5'h11;
         if (k == 3) mn = 7'h31;
         tick(2);
         chk({6'h00, flag, irq}, 8'h00);
         {clr, day, wd, mon, mn} = {1'b0, 6'h31, 3'h3, 5'h12, 7'h30};
         tick(1);
         chk({6'h00, flag, irq}, 8'h03);
      end
      {yr, clr} = {7'h78, 1'b1};
      tick(1);
      chk({6'h00, flag, irq}, 8'h00);
      yr = 7'h79;
      tick(1);
      chk({6'h00, flag, irq}, 8'h03);
      clr = 1'b0;
   endtask
   // Clock enable low freezes targets, read data and the flag.
   task automatic t_freeze();
      {ce, clr} = 2'b01;
      u_host.xfer(1'b1, 8'h10, 8'h00, q);
      u_host.xfer(1'b0, 8'h16, 8'h00, q);
      chk(q, 8'h00);
      chk({6'h00, flag, irq}, 8'h03);
      {ce, clr} = 2'b10;
      u_host.xfer(1'b0, 8'h10, 8'h00, q);
      chk(q, 8'hd9);
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      chk({6'h00, flag, irq}, 8'h00);
   endtask
   // A reset in mid-run clears read data and the seconds target.
   task automatic t_reset();
      nrst = 1'b0;
      tick(1);
      nrst = 1'b1;
      chk(rdata, 8'h00);
      u_host.xfer(1'b0, 8'h10, 8'h00, q);
      chk(q, 8'h00);
   endtask
   initial begin
      {nrst, en, clr, sec, yr, hr, day, mon, wd, mn} = 44'h0;
      ce = 1'b1;
      repeat (16) @(posedge clk);
      #1 nrst = 1'b1;
      t_regs();
      t_match();
      t_date();
      t_freeze();
      t_reset();
      end_of_test();
   end
   initial begin
      #100000;
      err_total++;
      end_of_test();
   end
endmodule
